// ===== ccd_pkg.sv
// Constants and types shared by the channel command decoder
package ccd_pkg;

   // ***********************************************
   // Clock and filter timing
   // ***********************************************
   localparam int CLK_PERIOD_NS  = 10;     // Core clock period
   localparam int EN_FILTER_NS   = 2000;   // Enable glitch window
   localparam int DIR_FILTER_NS  = 10000;  // Direction glitch window
   localparam int EN_FILTER_CYC  = (EN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIR_FILTER_CYC = (DIR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic FILT_RST     = 1'b0;   // Undriven pins read as low

   // ***********************************************
   // Analog scaling, kept as codes
   // ***********************************************
   localparam int SS_DONE_MV          = 230;    // Discharge comparator threshold
   localparam int SET_FULL_SCALE_MV   = 3125;   // Setpoint reference
   localparam logic [11:0] SET_FULL_CODE = 12'hfff;  // Code for full reference
   localparam logic [6:0]  SENSE_GAIN    = 7'h32;    // Amplifier gain of 50
   localparam int REG_RATIO_PERMILLE  = 20;     // Sense is 0.02 of setpoint

   // ***********************************************
   // Register map
   // ***********************************************
   localparam logic [7:0] CTRL_OFS     = 8'h00;  // Control
   localparam logic [7:0] STATUS_OFS   = 8'h04;  // Status
   localparam logic [7:0] SETPOINT_OFS = 8'h08;  // Setpoint level
   localparam int CTRL_SRC_BIT   = 0;            // 1: pulse setpoint source
   localparam logic CTRL_SRC_RST = 1'b0;         // Analog source after reset
   localparam int ST_EN1_BIT     = 0;
   localparam int ST_EN2_BIT     = 1;
   localparam int ST_DIRV_BIT    = 2;
   localparam int ST_BUCK_BIT    = 3;
   localparam int ST_SSREL_BIT   = 4;
   localparam int ST_ACT1_BIT    = 5;
   localparam int ST_ACT2_BIT    = 6;

   // ***********************************************
   // Soft-start timer states
   // ***********************************************
   typedef enum logic {
      SS_DISCHARGE,
      SS_RELEASED
   } ccd_ss_t;

endpackage

// ===== ccd_glitch_filter.sv
// Synchronising glitch filter for one slow control pin
`timescale 1ns/1ps
`default_nettype none
module ccd_glitch_filter #(
   parameter int STABLE_CYCLES = 200
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic raw_in,
   output logic      filt_out
);

   localparam int CW = $clog2(STABLE_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYCLES - 1);

   // All filter state
   typedef struct packed {
      logic          meta;   // First synchroniser stage
      logic          sync;   // Second synchroniser stage
      logic [CW-1:0] cnt;    // Cycles the new level has stood
      logic          filt;   // Accepted level
   } ccd_filt_st_t;

   ccd_filt_st_t st_q;
   ccd_filt_st_t st_d;

   // Next state: accept a level only once it stood the full window
   always_comb begin
      st_d      = st_q;
      st_d.meta = raw_in;
      st_d.sync = st_q.meta;
      if (st_q.sync == st_q.filt) begin
         st_d.cnt = '0;  // Short pulse restarts the count
      end else if (st_q.cnt == CNT_LAST) begin
         st_d.filt = st_q.sync;  // Stable for whole window
         st_d.cnt  = '0;
      end else begin
         st_d.cnt = st_q.cnt + 1'b1;
      end
   end

   // State register, low level after reset
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_q      <= '0;
         st_q.filt <= ccd_pkg::FILT_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign filt_out = st_q.filt;

   // Output moves only after a full stable window
   a_filter_window: assert property (@(posedge core_clk) disable iff (!rst_b)
      $changed(st_q.filt) |-> $past(st_q.cnt) == CNT_LAST && $past(st_q.sync) != $past(st_q.filt))
      else $error("filtered level changed before window elapsed");

   // Level back at accepted value holds the output
   a_filter_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q.sync == st_q.filt) |=> $stable(st_q.filt))
      else $error("filtered level moved without a new input level");

endmodule
`default_nettype wire

// ===== ccd_channel_command_decoder.sv
// Channel command decoder: enables, direction, soft start, setpoint, APB slave
// Summary of operation
// - Channel two needs channel one enabled
// - Enable one high starts channel via soft start
// - Enable one low forces channel one off
// - Enable two never touches soft-start timer
// - Undriven enable pins read as low
// - Enable filter drops pulses under 2 us
// - Direction high selects buck mode
// - Direction low selects boost mode
// - Invalid direction keeps standby, channels off
// - Direction flip discharges, then restarts soft start
// - Direction filter drops pulses under 10 us
// - Sense polarity follows filtered direction
// - Setpoint from analog or pulse input
// - Pulse setpoint is duty times full reference
// - Regulate sense to 0.02 of setpoint
// - Sense amplifier gain is fifty
// - Zero crossing turns off synchronous rectifier
// - Discharge soft start until below threshold
// - Soft start low holds both channels
`timescale 1ns/1ps
`default_nettype none
module ccd_channel_command_decoder (
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Host command pins
   input  wire logic              channel_one_enable,
   input  wire logic              channel_two_enable,
   input  wire logic              dir_high_pin,
   input  wire logic              dir_low_pin,
   input  wire logic              pulse_current_setpoint,
   input  wire logic [11:0]       analog_current_setpoint,
   // Analog front end
   input  wire logic              ss_below_done,
   input  wire logic signed [7:0] sense_diff_one,
   input  wire logic signed [7:0] sense_diff_two,
   // Controls to the power stage
   output logic                   ss_pulldown,
   output logic                   buck_mode,
   output logic                   sense_invert,
   output logic                   channel_one_active,
   output logic                   channel_two_active,
   output logic [11:0]            setpoint_level,
   output logic signed [14:0]     error_one,
   output logic signed [14:0]     error_two,
   output logic                   rect_off_one,
   output logic                   rect_off_two
);

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      ccd_pkg::ccd_ss_t    ss;        // Soft-start timer state
      logic                dir_lat;   // Direction of current soft start
      logic                src_pulse; // Setpoint source select
      logic [31:0]         prdata;    // Read data for access phase
      logic                pslverr;   // Error for access phase
      logic                ss_meta;   // Comparator sync stage one
      logic                ss_low;    // Soft start below threshold
      logic                p_meta;    // Pulse sync stage one
      logic                p_sync;    // Pulse sync stage two
      logic                p_prev;    // Pulse level last cycle
      logic [15:0]         hi_cnt;    // High cycles this period
      logic [15:0]         per_cnt;   // Cycles this period
      logic [11:0]         decoded;   // Last decoded duty code
      logic [11:0]         setpoint;  // Selected setpoint
      logic                act1;      // Channel one switching
      logic                act2;      // Channel two switching
      logic                buck;      // Buck mode
      logic                inv;       // Sense polarity inverted
      logic signed [14:0]  err1;      // Loop error channel one
      logic signed [14:0]  err2;      // Loop error channel two
      logic                rect1;     // Rectifier off channel one
      logic                rect2;     // Rectifier off channel two
   } ccd_st_t;

   ccd_st_t st_q;
   ccd_st_t st_d;

   // Filtered pins
   logic en1_f;
   logic en2_f;
   logic dir_hi_f;
   logic dir_lo_f;
   logic dir_valid;
   logic dir_buck;

   // ***********************************************
   // Pin filters
   // ***********************************************
   ccd_glitch_filter #(.STABLE_CYCLES(ccd_pkg::EN_FILTER_CYC)) u_en1_filt (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .raw_in   (channel_one_enable),
      .filt_out (en1_f)
   );
   ccd_glitch_filter #(.STABLE_CYCLES(ccd_pkg::EN_FILTER_CYC)) u_en2_filt (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .raw_in   (channel_two_enable),
      .filt_out (en2_f)
   );
   ccd_glitch_filter #(.STABLE_CYCLES(ccd_pkg::DIR_FILTER_CYC)) u_dirh_filt (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .raw_in   (dir_high_pin),
      .filt_out (dir_hi_f)
   );
   ccd_glitch_filter #(.STABLE_CYCLES(ccd_pkg::DIR_FILTER_CYC)) u_dirl_filt (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .raw_in   (dir_low_pin),
      .filt_out (dir_lo_f)
   );

   // Third state is neither or both comparators
   assign dir_valid = dir_hi_f ^ dir_lo_f;
   assign dir_buck  = dir_hi_f;  // Meaningful only while valid

   // ***********************************************
   // Helpers
   // ***********************************************
   // Polarity select then gain of fifty
   function automatic logic signed [13:0] amplify(input logic signed [7:0] d, input logic inv);
      logic signed [8:0]  p;
      logic signed [16:0] prod;
      p    = inv ? -9'(d) : 9'(d);
      prod = p * $signed({1'b0, ccd_pkg::SENSE_GAIN});
      return 14'(prod);
   endfunction

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      logic signed [13:0] amp1;
      logic signed [13:0] amp2;
      logic [27:0]        ratio;
      logic               rise;
      amp1  = '0;
      amp2  = '0;
      ratio = '0;
      rise  = 1'b0;
      st_d  = st_q;

      // Comparator and pulse synchronisers
      st_d.ss_meta = ss_below_done;
      st_d.ss_low  = st_q.ss_meta;
      st_d.p_meta  = pulse_current_setpoint;
      st_d.p_sync  = st_q.p_meta;
      st_d.p_prev  = st_q.p_sync;

      // Soft-start timer; enable two has no say here
      unique case (st_q.ss)
         ccd_pkg::SS_DISCHARGE: begin
            // Stay on until below threshold
            if (st_q.ss_low && en1_f && dir_valid) begin
               st_d.ss      = ccd_pkg::SS_RELEASED;
               st_d.dir_lat = dir_buck;              // New direction
            end
         end
         ccd_pkg::SS_RELEASED: begin
            if (!en1_f || !dir_valid) begin
               st_d.ss = ccd_pkg::SS_DISCHARGE;
            end else if (dir_buck != st_q.dir_lat) begin
               st_d.ss = ccd_pkg::SS_DISCHARGE;  // Restart on flip
            end
         end
      endcase

      // Channel gating follows the next timer state
      st_d.act1 = (st_d.ss == ccd_pkg::SS_RELEASED) && en1_f && dir_valid;
      st_d.act2 = st_d.act1 && en2_f;
      st_d.buck = st_d.dir_lat;  // 1 buck, 0 boost
      st_d.inv  = !dir_buck;     // Boost senses the other way

      // Duty decoder over whole pulse periods
      rise = st_q.p_sync && !st_q.p_prev;
      if (rise) begin
         if (st_q.per_cnt != 16'h0000) begin
            ratio        = 28'(st_q.hi_cnt) * 28'(ccd_pkg::SET_FULL_CODE);
            st_d.decoded = 12'(ratio / 28'(st_q.per_cnt));  // Duty times full scale
         end
         st_d.per_cnt = 16'h0001;
         st_d.hi_cnt  = 16'h0001;
      end else begin
         if (st_q.per_cnt != 16'hffff) begin
            st_d.per_cnt = st_q.per_cnt + 16'h0001;
            if (st_q.p_sync) begin
               st_d.hi_cnt = st_q.hi_cnt + 16'h0001;
            end
         end
      end

      // Setpoint source select
      st_d.setpoint = st_q.src_pulse ? st_q.decoded : analog_current_setpoint;

      // Loop error: gain 50 times 0.02 makes setpoint the amplified target
      amp1      = amplify(sense_diff_one, st_q.inv);
      amp2      = amplify(sense_diff_two, st_q.inv);
      st_d.err1 = 15'($signed({1'b0, st_q.setpoint}) - 15'(amp1));
      st_d.err2 = 15'($signed({1'b0, st_q.setpoint}) - 15'(amp2));

      // Zero crossing stops the rectifier
      st_d.rect1 = st_q.act1 && (amp1 <= 14'sh0000);
      st_d.rect2 = st_q.act2 && (amp2 <= 14'sh0000);

      // APB: decode in setup, answer in access
      if (psel && !penable) begin
         st_d.prdata  = 32'h0000_0000;
         st_d.pslverr = 1'b0;
         unique case (paddr)
            ccd_pkg::CTRL_OFS: begin
               st_d.prdata[ccd_pkg::CTRL_SRC_BIT] = st_q.src_pulse;
            end
            ccd_pkg::STATUS_OFS: begin
               st_d.prdata[ccd_pkg::ST_EN1_BIT]   = en1_f;
               st_d.prdata[ccd_pkg::ST_EN2_BIT]   = en2_f;
               st_d.prdata[ccd_pkg::ST_DIRV_BIT]  = dir_valid;
               st_d.prdata[ccd_pkg::ST_BUCK_BIT]  = st_q.buck;
               st_d.prdata[ccd_pkg::ST_SSREL_BIT] = (st_q.ss == ccd_pkg::SS_RELEASED);
               st_d.prdata[ccd_pkg::ST_ACT1_BIT]  = st_q.act1;
               st_d.prdata[ccd_pkg::ST_ACT2_BIT]  = st_q.act2;
            end
            ccd_pkg::SETPOINT_OFS: begin
               st_d.prdata[11:0] = st_q.setpoint;
            end
            default: begin
               st_d.pslverr = 1'b1;  // Unmapped address
            end
         endcase
      end
      if (psel && penable && pwrite && paddr == ccd_pkg::CTRL_OFS) begin
         st_d.src_pulse = pwdata[ccd_pkg::CTRL_SRC_BIT];
      end
   end

   // ***********************************************
   // State register
   // ***********************************************
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_q           <= '0;
         st_q.ss        <= ccd_pkg::SS_DISCHARGE;
         st_q.src_pulse <= ccd_pkg::CTRL_SRC_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   assign pready             = 1'b1;  // Zero wait states
   assign prdata             = st_q.prdata;
   assign pslverr            = st_q.pslverr;
   assign ss_pulldown        = (st_q.ss == ccd_pkg::SS_DISCHARGE);
   assign buck_mode          = st_q.buck;
   assign sense_invert       = st_q.inv;
   assign channel_one_active = st_q.act1;
   assign channel_two_active = st_q.act2;
   assign setpoint_level     = st_q.setpoint;
   assign error_one          = st_q.err1;
   assign error_two          = st_q.err2;
   assign rect_off_one       = st_q.rect1;
   assign rect_off_two       = st_q.rect2;

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_dir_flip;
      st_q.ss == ccd_pkg::SS_RELEASED && en1_f && dir_valid && dir_buck != st_q.dir_lat;
   endsequence
   sequence s_restart_hold;
      ss_pulldown && !channel_one_active && !channel_two_active;
   endsequence
   sequence s_release;
      st_q.ss == ccd_pkg::SS_DISCHARGE && st_q.ss_low && en1_f && dir_valid;
   endsequence

   a_ch2_needs_ch1: assert property (channel_two_active |-> channel_one_active)
      else $error("channel two active without channel one");
   a_ch1_start: assert property (s_release |=> channel_one_active && !ss_pulldown)
      else $error("channel one not started after discharge done");
   a_ch1_disable: assert property (!en1_f |=> !channel_one_active && ss_pulldown)
      else $error("channel one still active after enable low");
   a_ch2_no_timer: assert property ($changed(en2_f) && $stable(en1_f) && $stable(dir_hi_f)
      && $stable(dir_lo_f) && st_q.ss == ccd_pkg::SS_RELEASED |=> !ss_pulldown)
      else $error("enable two moved the soft-start timer");
   a_dir_invalid: assert property (!dir_valid |=> !channel_one_active && !channel_two_active)
      else $error("channel active with invalid direction");
   a_dir_restart: assert property (s_dir_flip |=> s_restart_hold)
      else $error("direction flip did not restart soft start");
   a_new_dir: assert property (s_release |=> buck_mode == $past(dir_buck, 1) ##1 buck_mode == $past(dir_buck, 2))
      else $error("buck mode does not follow the direction taken at release");
   a_disch_stays: assert property (ss_pulldown && !st_q.ss_low |=> ss_pulldown)
      else $error("soft start released before threshold");
   a_hold_both: assert property (ss_pulldown |-> !channel_one_active && !channel_two_active)
      else $error("channel active while soft start held low");
   a_polarity: assert property (dir_valid && !dir_buck |=> sense_invert)
      else $error("sense polarity wrong in boost");
   a_setpoint_hold: assert property (!(st_q.p_sync && !st_q.p_prev) |=> $stable(st_q.decoded))
      else $error("decoded setpoint changed between periods");
   a_rect_off: assert property (channel_one_active && sense_diff_one == 8'sh00 |=> rect_off_one)
      else $error("rectifier not turned off at zero current");

endmodule
`default_nettype wire

// ===== ccd_host_model.sv
// Host controller model driving the command pins of the decoder
`timescale 1ns/1ps
`default_nettype none
module ccd_host_model (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        en1_cmd,
   input  wire logic        en2_cmd,
   input  wire logic [1:0]  dir_cmd,
   input  wire logic        zero_req,
   input  wire logic [15:0] pwm_hi,
   input  wire logic [15:0] pwm_per,
   output logic             channel_one_enable,
   output logic             channel_two_enable,
   output logic             dir_high_pin,
   output logic             dir_low_pin,
   output logic             pulse_current_setpoint
);
   // ***********************************************
   // Pin drivers
   // ***********************************************
   logic [15:0] pwm_cnt_q;  // Position in setpoint period

   // Quiet pins before the first edge
   initial begin
      pwm_cnt_q = 16'h0000;
      channel_one_enable = 1'b0;
      channel_two_enable = 1'b0;
      dir_high_pin = 1'b1;
      dir_low_pin = 1'b0;
      pulse_current_setpoint = 1'b0;
   end

   // Pins change just after the clock edge
   always @(posedge core_clk) begin
      if (!rst_b || (pwm_cnt_q + 16'h0001 >= pwm_per)) begin
         pwm_cnt_q <= 16'h0000;
      end else begin
         pwm_cnt_q <= pwm_cnt_q + 16'h0001;
      end
      channel_one_enable <= en1_cmd & ~zero_req;  // Zero current by dropping enable one
      channel_two_enable <= en2_cmd;
      dir_high_pin <= (dir_cmd == 2'h1);  // Buck level
      dir_low_pin <= (dir_cmd == 2'h0);  // Boost level; code 2 is mid-rail
      pulse_current_setpoint <= (pwm_cnt_q < pwm_hi);
   end
endmodule
`default_nettype wire

// ===== tb_channel_command_decoder.sv
// Self-checking bench for the channel command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_channel_command_decoder;
   // ***********************************************
   // Signals
   // ***********************************************
   logic               core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata;
   logic               en1, en2, dir_hi, dir_lo, pwm_pin, ss_below_done;
   logic [11:0]        analog_sp, setpoint_level;
   logic signed [7:0]  sense_one, sense_two;
   logic               ss_pulldown, buck_mode, sense_invert, act_one, act_two, rect_one, rect_two;
   logic signed [14:0] error_one, error_two;
   logic               en1_cmd, en2_cmd, zero_req;
   logic [1:0]         dir_cmd;
   logic [15:0]        pwm_hi, pwm_per;
   int                 mismatches, check_count, sp, hi;
   localparam int      EW = ccd_pkg::EN_FILTER_CYC + 10;   // Enable settle wait
   localparam int      DW = ccd_pkg::DIR_FILTER_CYC + 20;  // Direction settle wait

   ccd_channel_command_decoder uut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .channel_one_enable(en1), .channel_two_enable(en2), .dir_high_pin(dir_hi), .dir_low_pin(dir_lo),
      .pulse_current_setpoint(pwm_pin), .analog_current_setpoint(analog_sp), .ss_below_done(ss_below_done),
      .sense_diff_one(sense_one), .sense_diff_two(sense_two), .ss_pulldown(ss_pulldown),
      .buck_mode(buck_mode), .sense_invert(sense_invert), .channel_one_active(act_one),
      .channel_two_active(act_two), .setpoint_level(setpoint_level), .error_one(error_one),
      .error_two(error_two), .rect_off_one(rect_one), .rect_off_two(rect_two));

   ccd_host_model host (.core_clk(core_clk), .rst_b(rst_b), .en1_cmd(en1_cmd), .en2_cmd(en2_cmd),
      .dir_cmd(dir_cmd), .zero_req(zero_req), .pwm_hi(pwm_hi), .pwm_per(pwm_per),
      .channel_one_enable(en1), .channel_two_enable(en2), .dir_high_pin(dir_hi), .dir_low_pin(dir_lo),
      .pulse_current_setpoint(pwm_pin));

   // ***********************************************
   // Tasks
   // ***********************************************
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Transfer with expected data and error flag
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] e, input logic ee);
      logic [31:0] d;
      logic        r;
      apb(wr, a, wd, d, r);
      if (!wr) chk(d, e);
      chk({31'h0, r}, {31'h0, ee});
   endtask

   // Model of the loop error: setpoint less amplified sense
   function automatic logic [31:0] exp_err(input int s, input int n);
      return {17'h0, 15'(s - n * 50)};
   endfunction

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ***********************************************
   // Clock, watchdog and test sequence
   // ***********************************************
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Cut a hang short
   initial begin
      cyc(40000);
      mismatches++;
      close_out();
   end

   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata, en1_cmd, en2_cmd, zero_req} = '0;
      {analog_sp, sense_one, sense_two, pwm_hi} = '0;
      ss_below_done = 1'b1;
      dir_cmd = 2'h1;
      pwm_per = 16'd100;
      mismatches = 0;
      check_count = 0;
      void'($urandom(32'h29deb7cc));
      cyc(4);
      rst_b <= 1'b1;
      cyc(1);
      chk(ss_pulldown, 1);
      xfer(0, ccd_pkg::CTRL_OFS, 0, 0, 0);
      xfer(1, ccd_pkg::STATUS_OFS, 32'hff, 0, 0);
      xfer(0, ccd_pkg::STATUS_OFS, 0, 0, 0);
      xfer(0, 8'h0c, 0, 0, 1);
      en2_cmd <= 1'b1;
      cyc(DW);
      chk(act_two, 0);
      chk(ss_pulldown, 1);
      en1_cmd <= 1'b1;
      cyc(ccd_pkg::EN_FILTER_CYC * 3 / 4);
      en1_cmd <= 1'b0;
      cyc(EW);
      chk(act_one, 0);
      en1_cmd <= 1'b1;
      cyc(EW);
      chk({act_one, act_two, ss_pulldown}, 3'b110);
      chk({buck_mode, sense_invert}, 2'b10);
      xfer(0, ccd_pkg::STATUS_OFS, 0, 32'h7f, 0);
      ss_below_done <= 1'b0;
      sp = $urandom_range(4095);
      analog_sp <= 12'(sp);
      sense_one <= 8'sd10;
      sense_two <= -8'sd3;
      cyc(5);
      chk(setpoint_level, sp);
      chk({17'h0, error_one}, exp_err(sp, 10));
      chk({17'h0, error_two}, exp_err(sp, -3));
      chk({rect_one, rect_two}, 2'b01);
      xfer(0, ccd_pkg::SETPOINT_OFS, 0, sp, 0);
      hi = $urandom_range(99, 1);
      pwm_hi <= 16'(hi);
      xfer(1, ccd_pkg::CTRL_OFS, 1, 0, 0);
      cyc(400);
      chk(setpoint_level, hi * 4095 / 100);
      en2_cmd <= 1'b0;
      cyc(EW);
      chk({act_two, ss_pulldown}, 0);
      en2_cmd <= 1'b1;
      cyc(EW);
      chk({act_one, act_two, ss_pulldown}, 3'b110);
      dir_cmd <= 2'h0;
      cyc(ccd_pkg::DIR_FILTER_CYC / 2);
      dir_cmd <= 2'h1;
      cyc(DW);
      chk({buck_mode, act_one, ss_pulldown}, 3'b110);
      dir_cmd <= 2'h0;
      cyc(DW);
      chk({ss_pulldown, act_one, act_two}, 3'b100);
      ss_below_done <= 1'b1;
      cyc(10);
      chk({act_one, act_two, ss_pulldown}, 3'b110);
      chk({buck_mode, sense_invert}, 2'b01);
      ss_below_done <= 1'b0;
      dir_cmd <= 2'h2;
      cyc(DW);
      chk({act_one, act_two}, 0);
      dir_cmd <= 2'h0;
      ss_below_done <= 1'b1;
      cyc(DW);
      chk(act_one, 1);
      zero_req <= 1'b1;
      cyc(EW);
      chk({act_one, act_two, ss_pulldown}, 3'b001);
      close_out();
   end
endmodule
`default_nettype wire
